// ---- crci_asserts.sv ----
// Checker for the link between the controller and one device.
// Assumes the bench instantiates it beside the link, joined by name.
`timescale 1ns/1ps
module crci_asserts (
  input wire logic MCLK, // Clock.
  input wire logic RST_N, // Reset.
  input wire logic reset_n, // Link reset.
  input wire logic cycle_enable_n, // Strobe.
  input wire logic address_valid_n, // Phase.
  input wire logic [31:0] data_lines, // Data.
  input wire logic match_chain_in_n, // Match in.
  input wire logic match_chain_out_n, // Match out.
  input wire logic full_chain_in_n, // Full in.
  input wire logic full_chain_out_n, // Full out.
  input wire logic local_match, // Result.
  input wire logic [3:0] page_address // Page.
);
  // ==========================================================================
  // Link rules
  // ==========================================================================
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  int low_cnt;
  logic [11:0] last_op;

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      low_cnt <= 0;
      last_op <= crci_pkg::OP_NOP;
    end
    else
    begin
      if (!reset_n)
        low_cnt <= low_cnt + 1;
      // Opcode of the latest instruction-load cycle; config writes also
      // move the page field and must not count as page loads.
      if (!cycle_enable_n && address_valid_n)
        last_op <= data_lines[11:0];
    end
  end

  match_chain_a: assert property (
    match_chain_out_n == (match_chain_in_n && !local_match))
    else $error("Match chain output wrong.");
  full_block_a: assert property (full_chain_in_n |-> full_chain_out_n)
    else $error("Full output low while full input high.");
  local_hold_a: assert property (
    reset_n && $changed(local_match) |->
    !$past(cycle_enable_n) || !$past(cycle_enable_n, 2))
    else $error("Match flag moved outside a cycle.");
  full_hold_a: assert property (
    reset_n && $changed(full_chain_out_n) && $stable(full_chain_in_n) |->
    !$past(cycle_enable_n) || !$past(cycle_enable_n, 2))
    else $error("Full flag moved outside a cycle.");
  page_full_a: assert property (
    reset_n && $changed(page_address) &&
    last_op == crci_pkg::OP_LOAD_PAGE |-> ##[0:2] !full_chain_out_n)
    else $error("Page load did not mark the device full.");
  reset_hold_a: assert property (
    $rose(reset_n) |-> low_cnt >= crci_pkg::RESET_HOLD_CYC)
    else $error("Link reset too short.");
  load_exec_a: assert property (
    !cycle_enable_n && address_valid_n |->
    !data_lines[13] ##2 (!cycle_enable_n && !address_valid_n))
    else $error("Instruction load not followed by execute.");
  strobe_a: assert property ($fell(cycle_enable_n) |=> cycle_enable_n)
    else $error("Strobe longer than one cycle.");

  cover property ($fell(full_chain_out_n));
  cover property ($rose(local_match));
  cover property ($rose(reset_n));
endmodule : crci_asserts

// ---- crci_ctrl.sv ----
// Controller end: Wishbone slave that sequences device cycles.
// Assumes one device link; chain delays are in cycles from the package.
`timescale 1ns/1ps
module crci_ctrl (
  input wire logic MCLK, // System clock.
  input wire logic RST_N, // Asynchronous reset, active low.
  input wire logic CYC_I, // Wishbone cycle.
  input wire logic STB_I, // Wishbone strobe.
  input wire logic WE_I, // Wishbone write enable.
  input wire logic [3:0] ADR_I, // Wishbone byte address.
  input wire logic [3:0] SEL_I, // Wishbone byte selects.
  input wire logic [31:0] DAT_I, // Wishbone write data.
  output logic [31:0] DAT_O, // Wishbone read data.
  output logic ACK_O, // Wishbone acknowledge.
  input wire logic [3:0] N_DEV, // Number of cascaded devices.
  crci_if.ctrl LINK // Device side.
);
  typedef enum logic [2:0] {
    CRCI_RESET = 3'b000, CRCI_IDLE = 3'b001, CRCI_LOAD = 3'b010,
    CRCI_EXEC = 3'b011, CRCI_RISE = 3'b100, CRCI_WAIT = 3'b101
  } crci_state_t;
  crci_state_t state;
  logic [7:0] count;
  logic [31:0] data;
  logic [2:0] cmd;
  logic busy;
  logic ack;
  logic [11:0] opcode;
  logic [7:0] settle;
  wire req = CYC_I & STB_I & ~ack;
  wire wr_cmd = req & WE_I & (ADR_I == crci_pkg::REG_CMD) & ~busy;
  wire wr_data = req & WE_I & (ADR_I == crci_pkg::REG_DATA) & SEL_I[0];

  always_comb
  begin
    case (crci_pkg::crci_cmd_t'(cmd))
      crci_pkg::CRCI_CMD_CONFIG: opcode = crci_pkg::OP_WRITE_CONFIG;
      crci_pkg::CRCI_CMD_PAGE: opcode = crci_pkg::OP_LOAD_PAGE;
      crci_pkg::CRCI_CMD_CLEAR: opcode = crci_pkg::OP_CLEAR_FULL;
      crci_pkg::CRCI_CMD_COMPARE: opcode = crci_pkg::OP_COMPARE;
      crci_pkg::CRCI_CMD_SRESET: opcode = crci_pkg::OP_RESET;
      crci_pkg::CRCI_CMD_DSEL: opcode = crci_pkg::OP_WRITE_DS;
      default: opcode = crci_pkg::OP_NOP;
    endcase
  end

  // Match settling: flag time plus one stage per extra device.
  assign settle = 8'(crci_pkg::FLAG_TIME_CYC) +
    8'(crci_pkg::STAGE_DELAY_CYC) * ({4'h0, N_DEV} - 8'h01);

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ack <= 1'b0;
      DAT_O <= 32'h0000_0000;
    end
    else
    begin
      ack <= req & ~(WE_I & ADR_I == crci_pkg::REG_CMD & busy);
      case (ADR_I)
        crci_pkg::REG_DATA: DAT_O <= data;
        crci_pkg::REG_STATUS: DAT_O <= {28'h0000000, LINK.local_match,
          ~LINK.full_chain_out_n, ~LINK.match_chain_out_n, busy};
        default: DAT_O <= 32'h0000_0000;
      endcase
    end
  end
  assign ACK_O = ack;
  assign busy = (state != CRCI_IDLE);

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state <= CRCI_RESET;
      count <= 8'h00;
      data <= 32'h0000_0000;
      cmd <= 3'b000;
      LINK.reset_n <= 1'b0;
      LINK.cycle_enable_n <= 1'b1;
      LINK.address_valid_n <= 1'b1;
      LINK.data_lines <= 32'h0000_0000;
    end
    else
    begin
      if (wr_data)
        data <= DAT_I;
      case (state)
        CRCI_RESET:
        begin
          count <= count + 8'h01;
          if (count == 8'(crci_pkg::RESET_HOLD_CYC))
          begin
            LINK.reset_n <= 1'b1;
            state <= CRCI_IDLE;
          end
        end
        CRCI_IDLE:
          if (wr_cmd && DAT_I[2:0] != 3'b000)
          begin
            cmd <= DAT_I[2:0];
            state <= CRCI_LOAD;
          end
        CRCI_LOAD:
        begin
          LINK.address_valid_n <= 1'b1;
          LINK.data_lines <= {18'h00000, 1'b0, 1'b0, opcode};
          LINK.cycle_enable_n <= 1'b0;
          state <= CRCI_EXEC;
        end
        CRCI_EXEC:
        begin
          LINK.cycle_enable_n <= 1'b1;
          if (!LINK.address_valid_n)
            state <= CRCI_RISE;
          else
          begin
            LINK.address_valid_n <= 1'b0;
            LINK.data_lines <= data;
            state <= CRCI_WAIT;
            count <= 8'h00;
          end
        end
        CRCI_WAIT:
        begin
          LINK.cycle_enable_n <= 1'b0;
          state <= CRCI_EXEC;
        end
        CRCI_RISE:
        begin
          count <= count + 8'h01;
          if ((cmd == 3'(crci_pkg::CRCI_CMD_COMPARE) && count >= settle) ||
            (cmd == 3'(crci_pkg::CRCI_CMD_PAGE) &&
            count >= 8'(crci_pkg::FULL_SPACING_CYC)) ||
            (cmd != 3'(crci_pkg::CRCI_CMD_COMPARE) &&
            cmd != 3'(crci_pkg::CRCI_CMD_PAGE)))
          begin
            LINK.address_valid_n <= 1'b1;
            state <= CRCI_IDLE;
          end
        end
        default: state <= CRCI_IDLE;
      endcase
    end
  end

  // Single device: select it directly; the external prioritizer with
  // several devices would gate these by the match flags instead.
  assign LINK.chip_select_a_n = 1'b0;
  assign LINK.chip_select_b_n = 1'b1;
  assign LINK.output_enable_n = busy;

endmodule : crci_ctrl

// ---- crci_device.sv ----
// Device end: instruction register, configuration, selection and chains.
// Assumes the controller obeys the cycle protocol; one-cycle strobe pulses.
`timescale 1ns/1ps

module crci_device (
  input wire logic MCLK, // System clock.
  input wire logic RST_N, // Asynchronous reset, active low.
  crci_if.device LINK, // Controller and chain side.
  input wire logic [31:0] ENTRY, // Stored entry to compare against.
  output logic HW_MODE, // High in hardware control mode.
  output logic [31:0] CONFIG // Configuration register contents.
);
  logic [11:0] instr;
  logic instr_read;
  logic [31:0] config_reg;
  logic [31:0] dsel;
  logic hw_mode;
  logic full;
  logic match;
  logic enable_d;
  logic strobe_fall;
  logic strobe_rise;
  logic selected;
  logic hit;
  logic load_instr;
  logic exec;
  logic is_wr;
  logic soft_reset;
  logic [3:0] page;
  logic wr_exec;
  logic do_config;
  logic do_dsel;
  logic do_page;
  logic do_clear;
  logic do_cmp;

  // ==========================================================================
  // Strobe edges, selection and decode
  // ==========================================================================
  assign strobe_fall = enable_d & ~LINK.cycle_enable_n;
  assign strobe_rise = ~enable_d & LINK.cycle_enable_n;
  assign page = config_reg[3:0];
  assign selected = ~LINK.chip_select_a_n | ~LINK.chip_select_b_n |
    (~dsel[crci_pkg::SELECT_DISABLE_POS] &
    (dsel[3:0] == page));
  assign load_instr = strobe_fall & selected & LINK.address_valid_n;
  assign exec = strobe_fall & selected & ~LINK.address_valid_n;
  assign is_wr = ~instr_read;
  assign soft_reset = exec & is_wr & (instr == crci_pkg::OP_RESET);
  // A held instruction runs again on every execute cycle, in hardware mode
  // too, since only instruction loads are shut off there.
  assign wr_exec = exec & is_wr;
  assign do_config = wr_exec & (instr == crci_pkg::OP_WRITE_CONFIG);
  assign do_dsel = wr_exec & (instr == crci_pkg::OP_WRITE_DS);
  // Only the top non-full device sees a low full input while not full.
  assign do_page = wr_exec & (instr == crci_pkg::OP_LOAD_PAGE) &
    ~LINK.full_chain_in_n & ~full;
  assign do_clear = wr_exec & (instr == crci_pkg::OP_CLEAR_FULL);
  assign do_cmp = wr_exec & (instr == crci_pkg::OP_COMPARE);
  // Parallel local compare; sampled at the execute strobe fall, moved into the flag at strobe rise.
  assign hit = (LINK.data_lines == ENTRY);

  // ==========================================================================
  // Instruction register and configuration
  // ==========================================================================
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      enable_d <= 1'b1;
      instr <= crci_pkg::OP_NOP;
      instr_read <= 1'b0;
      config_reg <= crci_pkg::CONFIG_RESET;
      dsel <= crci_pkg::DS_RESET;
      hw_mode <= 1'b0;
    end
    else if (!LINK.reset_n)
    begin
      // The link reset is taken on the clock, so a short pulse on the shared
      // line cannot leave the device halfway through a cycle.
      enable_d <= 1'b1;
      instr <= crci_pkg::OP_NOP;
      instr_read <= 1'b0;
      config_reg <= crci_pkg::CONFIG_RESET;
      dsel <= crci_pkg::DS_RESET;
      hw_mode <= 1'b0;
    end
    else
    begin
      enable_d <= LINK.cycle_enable_n;
      if (soft_reset)
      begin
        // Software reset keeps the lowest-priority bit as it stands.
        instr <= crci_pkg::OP_NOP;
        instr_read <= 1'b0;
        hw_mode <= 1'b0;
        dsel <= crci_pkg::DS_RESET;
      end
      else if (load_instr && !hw_mode)
      begin
        instr <= LINK.data_lines[11:0];
        instr_read <= LINK.data_lines[crci_pkg::WRITE_SELECT_POS];
      end
      else
      begin
        if (do_config)
        begin
          config_reg <= LINK.data_lines;
          hw_mode <= (LINK.data_lines[crci_pkg::MODE_HI_POS:
            crci_pkg::MODE_LO_POS] == crci_pkg::MODE_HARDWARE);
        end
        if (do_dsel)
          dsel <= LINK.data_lines;
        if (do_page)
          config_reg[3:0] <= dsel[3:0];
      end
    end
  end

  // ==========================================================================
  // Flags: change only when the strobe returns high
  // ==========================================================================
  // Results wait in these until the strobe returns high.
  logic pend_page;
  logic pend_clear;
  logic pend_cmp;
  logic pend_hit;
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      full <= 1'b0;
      match <= 1'b0;
      pend_page <= 1'b0;
      pend_clear <= 1'b0;
      pend_cmp <= 1'b0;
      pend_hit <= 1'b0;
    end
    else if (!LINK.reset_n)
    begin
      full <= 1'b0;
      match <= 1'b0;
      pend_page <= 1'b0;
      pend_clear <= 1'b0;
      pend_cmp <= 1'b0;
      pend_hit <= 1'b0;
    end
    else
    begin
      if (wr_exec)
      begin
        pend_page <= do_page;
        pend_clear <= do_clear;
        pend_cmp <= do_cmp;
        pend_hit <= hit;
      end
      // Set and clear never meet: each comes from its own instruction.
      if (strobe_rise)
      begin
        if (pend_page)
          full <= 1'b1;
        if (pend_clear)
          full <= 1'b0;
        if (pend_cmp)
          match <= pend_hit;
        pend_page <= 1'b0;
        pend_clear <= 1'b0;
        pend_cmp <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Chain and status outputs
  // ==========================================================================
  assign LINK.match_chain_out_n = LINK.match_chain_in_n & ~match;
  // A full device under a free one keeps its output high, so a gap anywhere
  // above still lets the next write through.
  assign LINK.full_chain_out_n = ~(~LINK.full_chain_in_n & full);
  assign LINK.local_match = match;
  assign LINK.page_address = page;
  assign HW_MODE = hw_mode;
  assign CONFIG = config_reg;

endmodule : crci_device

// ---- crci_if.sv ----
// Link between the packet controller and one cascaded device.
// Assumes the bench drives the chain inputs of its one device directly.
`timescale 1ns/1ps
interface crci_if;
  logic reset_n;
  logic cycle_enable_n;
  logic address_valid_n;
  logic chip_select_a_n;
  logic chip_select_b_n;
  logic output_enable_n;
  logic [31:0] data_lines;
  logic match_chain_in_n;
  logic match_chain_out_n;
  logic full_chain_in_n;
  logic full_chain_out_n;
  logic local_match;
  logic [3:0] page_address;

  modport device (
    input reset_n, cycle_enable_n, address_valid_n, chip_select_a_n,
    input chip_select_b_n, output_enable_n, data_lines,
    input match_chain_in_n, full_chain_in_n,
    output match_chain_out_n, full_chain_out_n, local_match, page_address
  );
  modport ctrl (
    output reset_n, cycle_enable_n, address_valid_n, chip_select_a_n,
    output chip_select_b_n, output_enable_n, data_lines,
    input match_chain_out_n, full_chain_out_n, local_match
  );
endinterface : crci_if

// ---- crci_pkg.sv ----
// Package for the cascade reset and configuration init block.
// Assumes a single 200 MHz clock shared by the controller and every device.
package crci_pkg;

  // ==========================================================================
  // Opcodes, fields and positions
  // ==========================================================================
  localparam logic [11:0] OP_WRITE_CONFIG = 12'h006;
  localparam logic [11:0] OP_LOAD_PAGE = 12'h03C;
  localparam logic [11:0] OP_CLEAR_FULL = 12'h03D;
  localparam logic [11:0] OP_RESET = 12'h03F;
  localparam logic [11:0] OP_COMPARE = 12'h019;
  localparam logic [11:0] OP_WRITE_DS = 12'h008;
  localparam logic [11:0] OP_NOP = 12'h003;
  localparam int OPCODE_WIDTH = 12;
  localparam int WRITE_SELECT_POS = 13;
  localparam int LOWEST_PRIORITY_POS = 25;
  localparam int MODE_LO_POS = 26;
  localparam int MODE_HI_POS = 27;
  localparam int SELECT_DISABLE_POS = 8;
  localparam logic [1:0] MODE_HARDWARE = 2'h0;
  localparam logic [31:0] CONFIG_RESET = 32'h0200_0000;
  localparam logic [31:0] DS_RESET = 32'h0000_0100;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RESET_HOLD_NS = 50;
  localparam int RESET_HOLD_CYC =
    (RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FLAG_TIME_CYC = 2;
  localparam int STAGE_DELAY_CYC = 1;
  localparam int FULL_SPACING_CYC = 2;

  // Controller command codes from its Wishbone command register.
  typedef enum logic [2:0] {
    CRCI_CMD_NONE = 3'b000,
    CRCI_CMD_CONFIG = 3'b001,
    CRCI_CMD_PAGE = 3'b010,
    CRCI_CMD_CLEAR = 3'b011,
    CRCI_CMD_COMPARE = 3'b100,
    CRCI_CMD_SRESET = 3'b101,
    CRCI_CMD_DSEL = 3'b110
  } crci_cmd_t;

  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_DATA = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_PRIO = 4'hC;

endpackage : crci_pkg

// ---- crci_test.sv ----
// Bench joining the controller and one device over the link.
// Assumes the package constants and a 200 MHz clock.
`timescale 1ns/1ps
module crci_test;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic ack;
  logic [3:0] n_dev = 4'h1;
  logic [31:0] entry = 32'h0;
  logic hw_mode;
  logic [31:0] cfg;
  logic [31:0] q;
  logic [31:0] exp_cfg;
  logic [31:0] exp_ds;
  logic exp_hw;
  logic exp_full;
  logic exp_hit;
  int error_cnt = 0;
  int comparisons = 0;
  int seed = 32'h68CF;
  int i;
  int k;

  crci_if lnk();
  crci_ctrl i_crci_ctrl (.MCLK(MCLK), .RST_N(RST_N), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dat),
    .DAT_O(dat_o), .ACK_O(ack), .N_DEV(n_dev), .LINK(lnk.ctrl));
  crci_device i_crci_device (.MCLK(MCLK), .RST_N(RST_N),
    .LINK(lnk.device), .ENTRY(entry), .HW_MODE(hw_mode), .CONFIG(cfg));
  crci_asserts i_crci_asserts (.MCLK(MCLK), .RST_N(RST_N),
    .reset_n(lnk.reset_n), .cycle_enable_n(lnk.cycle_enable_n),
    .address_valid_n(lnk.address_valid_n), .data_lines(lnk.data_lines),
    .match_chain_in_n(lnk.match_chain_in_n),
    .match_chain_out_n(lnk.match_chain_out_n),
    .full_chain_in_n(lnk.full_chain_in_n),
    .full_chain_out_n(lnk.full_chain_out_n),
    .local_match(lnk.local_match), .page_address(lnk.page_address));

  always #2.5 MCLK = ~MCLK;

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic give_verdict;
    if (error_cnt == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic hang;
    error_cnt++;
    give_verdict();
  endtask : hang

  // Inputs are read just after the edge, so they hold the sampled values.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge MCLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    for (n = 0; n < 100 && ack !== 1'b1; n++)
      @(posedge MCLK);
    if (ack !== 1'b1)
      hang();
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic cmd(input logic [2:0] c, input logic [31:0] d);
    int n;
    wb(1'b1, crci_pkg::REG_DATA, d);
    wb(1'b1, crci_pkg::REG_CMD, {29'h0, c});
    q = 32'h1;
    for (n = 0; n < 300 && q[0] !== 1'b0; n++)
      wb(1'b0, crci_pkg::REG_STATUS, 32'h0);
    if (q[0] !== 1'b0)
      hang();
    if (exp_hw)
      return;
    if (c == 3'h2 && !lnk.full_chain_in_n && !exp_full)
    begin
      exp_cfg[3:0] = exp_ds[3:0];
      exp_full = 1'b1;
    end
    exp_full = exp_full && c != 3'h3;
    if (c == 3'h4)
      exp_hit = d == entry;
    if (c == 3'h6)
      exp_ds = d;
    if (c == 3'h5)
      exp_ds = crci_pkg::DS_RESET;
    if (c == 3'h1)
      exp_cfg = d;
    exp_hw = c == 3'h1 && d[27:26] == crci_pkg::MODE_HARDWARE;
  endtask : cmd

  task automatic verify;
    chk("config", cfg, exp_cfg);
    chk("mode", {31'h0, hw_mode}, {31'h0, exp_hw});
    chk("page", {28'h0, lnk.page_address}, {28'h0, exp_cfg[3:0]});
    chk("full", {31'h0, lnk.full_chain_out_n},
      {31'h0, lnk.full_chain_in_n || !exp_full});
  endtask : verify

  task automatic reset_all;
    RST_N <= 1'b0;
    repeat (12)
      @(posedge MCLK);
    RST_N <= 1'b1;
    for (i = 0; i < 100 && lnk.reset_n !== 1'b1; i++)
      @(posedge MCLK);
    if (lnk.reset_n !== 1'b1)
      hang();
    exp_cfg = crci_pkg::CONFIG_RESET;
    exp_ds = crci_pkg::DS_RESET;
    exp_hw = 1'b0;
    exp_full = 1'b0;
    exp_hit = 1'b0;
    chk("reset config", cfg, exp_cfg);
    chk("reset mode", {31'h0, hw_mode}, 32'h0);
  endtask : reset_all

  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial
  begin
    lnk.match_chain_in_n = 1'b1;
    lnk.full_chain_in_n = 1'b0;
    reset_all();
    cmd(3'h1, (32'($random(seed)) & 32'hF1FF_FFFF) | 32'h0400_0000);
    verify();
    cmd(3'h6, 32'h5);
    cmd(3'h2, 32'h0);
    verify();
    // A second load must pass over the device that is already full.
    cmd(3'h6, 32'h9);
    cmd(3'h2, 32'h0);
    verify();
    lnk.full_chain_in_n <= 1'b1;
    cmd(3'h3, 32'h0);
    cmd(3'h2, 32'h0);
    verify();
    lnk.full_chain_in_n <= 1'b0;
    cmd(3'h2, 32'h0);
    verify();
    cmd(3'h3, 32'h0);
    verify();
    for (k = 0; k < 6; k++)
    begin
      @(posedge MCLK);
      entry <= $random(seed);
      n_dev <= 4'h1 + 4'(k);
      lnk.match_chain_in_n <= 1'($random(seed));
      @(posedge MCLK);
      cmd(3'h4, k[0] ? entry : entry ^ 32'h10);
      chk("hit", {31'h0, lnk.local_match}, {31'h0, exp_hit});
      chk("status hit", {31'h0, q[3]}, {31'h0, exp_hit});
      chk("match out", {31'h0, lnk.match_chain_out_n},
        {31'h0, lnk.match_chain_in_n && !exp_hit});
    end
    // Unmapped place: only the answer is awaited.
    wb(1'b0, 4'h2, 32'h0);
    cmd(3'h5, 32'h0);
    chk("soft reset mode", {31'h0, hw_mode}, 32'h0);
    verify();
    // The cleared select value now lands as page zero.
    cmd(3'h2, 32'h0);
    verify();
    cmd(3'h1, 32'($random(seed)) & 32'hF3FF_FFFF);
    verify();
    // Hardware mode ignores the load; the held config write reruns unchanged.
    cmd(3'h2, exp_cfg);
    verify();
    reset_all();
    verify();
    give_verdict();
  end
endmodule : crci_test
